// [common/rtoc_pkg.sv]
// Constants, register map and field layout of the real-time output port.
// Assumes an 8-bit special-function-register bus inside the CPU.
// Summary of operation
// - Reset clears control to zero: disabled, nibble mode, no ext trigger.
// - Control bit 7 enables transfers from buffers to the output latch.
// - Control bit 5 selects two 4-bit channels (0) or one 8-bit channel (1).
// - Control bit 4 makes external interrupt two a transfer trigger.
// - Mode and trigger bits route timer one, timer two or the ext interrupt.
// - Setting the enable bit copies both buffers into the latch at once.
// - Only pins marked in the pin mode register drive transferred data.
// - A real-time pin drives the port latch ORed with the real-time latch.
// - The external trigger edge is picked by rise and fall edge enables.
// - A pin mode bit at 1 selects real-time output; it resets to zero.
// - Nibbles write apart, byte mode loads both; port-mode bits read 0.
package rtoc_pkg;
    localparam logic [15:0] RTOC_ADDR_BUF_LOW = 16'hff98;
    localparam logic [15:0] RTOC_ADDR_BUF_HIGH = 16'hff99;
    localparam logic [15:0] RTOC_ADDR_PIN_MODE = 16'hff9a;
    localparam logic [15:0] RTOC_ADDR_CONTROL = 16'hff9b;
    localparam logic [7:0] RTOC_CONTROL_RESET = 8'h00;
    localparam logic [7:0] RTOC_PIN_MODE_RESET = 8'h00;
    localparam logic [7:0] RTOC_CONTROL_MASK = 8'hb0;
    localparam int RTOC_BIT_ENABLE = 7;
    localparam int RTOC_BIT_BYTE = 5;
    localparam int RTOC_BIT_EXT = 4;

    // Decoded control fields.
    typedef struct packed {
        logic enable;
        logic byte_mode;
        logic ext_sel;
    } rtoc_ctrl_t;
endpackage

// [dv/rtoc_load_model.sv]
// Load model: the driver stage that sits on the real-time output pins.
// Assumes the load samples the pins on the rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module rtoc_load_model
(
    input wire logic clk,
    input wire logic [7:0] pins,
    output logic [7:0] load_state
);
    // Latch on the clock, so a combinational glitch never counts as a step.
    always_ff @(posedge clk)
    begin
        load_state <= pins;
    end
endmodule
`default_nettype wire

// [dv/rtoc_port_tb.sv]
// Testbench for the real-time output port, driven through its SFR bus.
// Assumes trigger pulses and the external pin are synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module rtoc_port_tb
    import rtoc_pkg::*;
;
    logic clk = 0;
    logic rst = 1;
    logic clk_en = 1;
    logic [15:0] sfr_addr = 16'h0000;
    logic sfr_wr = 0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic sfr_hit;
    logic t1 = 0;
    logic t2 = 0;
    logic ext = 0;
    logic rise_en = 0;
    logic fall_en = 0;
    logic [7:0] port_latch = 8'h00;
    logic [7:0] pins;
    logic [7:0] sel;
    logic [7:0] load_state;
    int n_fail = 0;
    int compares = 0;
    // Clock at 20 MHz.
    always #25 clk = ~clk;
    rtoc_port #(.WIDTH(8)) rtoc_port_i (.clk(clk), .rst(rst), .clk_en(clk_en),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .timer_one_match_irq(t1),
        .timer_two_match_irq(t2), .ext_irq_pin(ext),
        .rise_edge_enable_reg(rise_en), .fall_edge_enable_reg(fall_en),
        .port_latch(port_latch), .rto_output_pins(pins), .rto_pin_sel(sel));
    rtoc_load_model rtoc_load_model_i (.clk(clk), .pins(pins),
        .load_state(load_state));
    task automatic summarize;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
            $display("CHECK FAILED at %0t: exp %h got %h", $time, exp, got);
        if (got !== exp)
            n_fail++;
    endtask
    // One idle cycle follows each write so the strobe is a clean pulse.
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1;
        @(negedge clk);
        sfr_wr = 0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(negedge clk);
        sfr_addr = a;
        #1;
        chk(exp, sfr_rdata);
    endtask
    // Bit 2 is the external pin level, bits 1 and 0 the timer pulses.
    task automatic trig(input logic [2:0] v);
        @(negedge clk);
        {ext, t2, t1} = v;
        @(negedge clk);
        {t2, t1} = 2'b00;
    endtask
    // The load model lags the pins by one edge, so look one cycle later.
    task automatic pchk(input logic [7:0] exp);
        @(negedge clk);
        chk(exp, load_state);
    endtask
    // Watchdog: the tests need a few hundred cycles at most.
    initial
    begin
        #200000;
        n_fail++;
        summarize();
    end
    // Main sequence.
    initial
    begin
        repeat (10) @(negedge clk);
        rst = 0;
        rd(RTOC_ADDR_CONTROL, 8'h00);
        rd(RTOC_ADDR_PIN_MODE, 8'h00);
        rd(16'hff97, 8'h00);
        chk(8'h00, {7'h00, sfr_hit});
        wr(RTOC_ADDR_CONTROL, 8'h4f);
        rd(RTOC_ADDR_CONTROL, 8'h00);
        $display("test reset done");
        wr(RTOC_ADDR_PIN_MODE, 8'hff);
        chk(8'hff, sel);
        wr(RTOC_ADDR_BUF_LOW, 8'ha5);
        wr(RTOC_ADDR_BUF_HIGH, 8'h3c);
        rd(RTOC_ADDR_BUF_LOW, 8'h35);
        trig(3'b001);
        pchk(8'h00);
        wr(RTOC_ADDR_CONTROL, 8'h80);
        pchk(8'h35);
        port_latch = 8'h40;
        pchk(8'h75);
        port_latch = 8'h00;
        $display("test enable done");
        wr(RTOC_ADDR_BUF_LOW, 8'h0a);
        wr(RTOC_ADDR_BUF_HIGH, 8'h90);
        trig(3'b001);
        pchk(8'h3a);
        trig(3'b010);
        pchk(8'h9a);
        wr(RTOC_ADDR_BUF_LOW, 8'h01);
        wr(RTOC_ADDR_BUF_HIGH, 8'h60);
        trig(3'b011);
        pchk(8'h61);
        $display("test nibble done");
        wr(RTOC_ADDR_CONTROL, 8'h90);
        rd(RTOC_ADDR_CONTROL, 8'h90);
        wr(RTOC_ADDR_BUF_LOW, 8'h02);
        wr(RTOC_ADDR_BUF_HIGH, 8'h70);
        trig(3'b001);
        pchk(8'h71);
        rise_en = 1;
        trig(3'b100);
        pchk(8'h72);
        trig(3'b000);
        pchk(8'h72);
        $display("test external done");
        wr(RTOC_ADDR_CONTROL, 8'ha0);
        wr(RTOC_ADDR_BUF_LOW, 8'hc4);
        rd(RTOC_ADDR_BUF_HIGH, 8'hc4);
        trig(3'b010);
        pchk(8'h72);
        trig(3'b001);
        pchk(8'hc4);
        wr(RTOC_ADDR_CONTROL, 8'hb0);
        rise_en = 0;
        fall_en = 1;
        wr(RTOC_ADDR_BUF_HIGH, 8'h5b);
        trig(3'b101);
        pchk(8'hc4);
        trig(3'b000);
        pchk(8'h5b);
        $display("test byte done");
        wr(RTOC_ADDR_PIN_MODE, 8'h0f);
        port_latch = 8'h30;
        pchk(8'h3b);
        rd(RTOC_ADDR_BUF_LOW, 8'h0b);
        $display("test pin mode done");
        wr(RTOC_ADDR_CONTROL, 8'ha0);
        wr(RTOC_ADDR_BUF_LOW, 8'h11);
        clk_en = 0;
        trig(3'b001);
        pchk(8'h3b);
        clk_en = 1;
        trig(3'b001);
        pchk(8'h31);
        wr(RTOC_ADDR_CONTROL, 8'h20);
        wr(RTOC_ADDR_BUF_LOW, 8'h22);
        trig(3'b001);
        pchk(8'h31);
        wr(RTOC_ADDR_BUF_LOW, 8'h11);
        wr(RTOC_ADDR_CONTROL, 8'ha0);
        pchk(8'h31);
        rd(RTOC_ADDR_BUF_HIGH, 8'h01);
        rd(RTOC_ADDR_CONTROL, 8'ha0);
        chk(8'h01, {7'h00, sfr_hit});
        $display("test reenable done");
        @(negedge clk);
        rst = 1;
        repeat (2) @(negedge clk);
        rst = 0;
        rd(RTOC_ADDR_CONTROL, 8'h00);
        rd(RTOC_ADDR_PIN_MODE, 8'h00);
        rd(RTOC_ADDR_BUF_LOW, 8'h00);
        pchk(8'h30);
        $display("test reset again done");
        summarize();
    end
endmodule
`default_nettype wire

// [src/rtoc_port.sv]
// Real-time output port: buffers, control, trigger routing and pin mixing.
// Assumes a synchronous SFR bus with one-cycle write strobe and
// trigger pulses already synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module rtoc_port
    import rtoc_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [15:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    input wire logic timer_one_match_irq,
    input wire logic timer_two_match_irq,
    input wire logic ext_irq_pin,
    input wire logic rise_edge_enable_reg,
    input wire logic fall_edge_enable_reg,
    input wire logic [WIDTH-1:0] port_latch,
    output logic [WIDTH-1:0] rto_output_pins,
    output logic [WIDTH-1:0] rto_pin_sel
);
    localparam int HALF = WIDTH / 2;

    logic [7:0] ctrl_r, ctrl_nxt;
    logic [WIDTH-1:0] mode_r, mode_nxt;
    logic [WIDTH-1:0] buf_r, buf_nxt;
    logic [WIDTH-1:0] latch_r, latch_nxt;
    logic ext_prev_r, ext_prev_nxt;
    rtoc_ctrl_t ctl;
    logic external_irq_two;
    logic trig_hi, trig_lo, en_rise;
    logic wr_ctrl, wr_mode, wr_lo, wr_hi;

    assign ctl.enable = ctrl_r[RTOC_BIT_ENABLE];
    assign ctl.byte_mode = ctrl_r[RTOC_BIT_BYTE];
    assign ctl.ext_sel = ctrl_r[RTOC_BIT_EXT];

    // Address decode for the four registers.
    assign wr_ctrl = sfr_wr && (sfr_addr == RTOC_ADDR_CONTROL);
    assign wr_mode = sfr_wr && (sfr_addr == RTOC_ADDR_PIN_MODE);
    assign wr_lo = sfr_wr && (sfr_addr == RTOC_ADDR_BUF_LOW);
    assign wr_hi = sfr_wr && (sfr_addr == RTOC_ADDR_BUF_HIGH);

    // External edge detect; both edge enables may be set at once.
    assign external_irq_two = (rise_edge_enable_reg && ext_irq_pin
        && !ext_prev_r) || (fall_edge_enable_reg && !ext_irq_pin
        && ext_prev_r);

    // Trigger routing per mode and trigger select.
    always_comb
    begin
        unique case ({ctl.byte_mode, ctl.ext_sel})
            2'b00:
            begin
                trig_hi = timer_two_match_irq;
                trig_lo = timer_one_match_irq;
            end
            2'b01:
            begin
                trig_hi = timer_one_match_irq;
                trig_lo = external_irq_two;
            end
            2'b10:
            begin
                trig_hi = timer_one_match_irq;
                trig_lo = timer_one_match_irq;
            end
            2'b11:
            begin
                trig_hi = external_irq_two;
                trig_lo = external_irq_two;
            end
        endcase
    end

    // Rising edge of the enable bit, from a control write.
    assign en_rise = wr_ctrl && sfr_wdata[RTOC_BIT_ENABLE] && !ctl.enable;

    // Next state of registers and the real-time latch.
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        mode_nxt = mode_r;
        buf_nxt = buf_r;
        latch_nxt = latch_r;
        ext_prev_nxt = ext_irq_pin;
        if (wr_ctrl)
        begin
            ctrl_nxt = sfr_wdata & RTOC_CONTROL_MASK;
        end
        if (wr_mode)
        begin
            mode_nxt = sfr_wdata[WIDTH-1:0];
        end
        // Byte mode takes the whole byte at either address.
        if ((wr_lo || wr_hi) && ctl.byte_mode)
        begin
            buf_nxt = sfr_wdata[WIDTH-1:0];
        end
        else
        begin
            if (wr_lo)
            begin
                buf_nxt[HALF-1:0] = sfr_wdata[HALF-1:0];
            end
            if (wr_hi)
            begin
                buf_nxt[WIDTH-1:HALF] = sfr_wdata[WIDTH-1:HALF];
            end
        end
        // Enable edge copies at once; otherwise each half on its trigger.
        if (en_rise)
        begin
            latch_nxt = buf_r;
        end
        else if (ctl.enable)
        begin
            if (trig_hi)
            begin
                latch_nxt[WIDTH-1:HALF] = buf_r[WIDTH-1:HALF];
            end
            if (trig_lo)
            begin
                latch_nxt[HALF-1:0] = buf_r[HALF-1:0];
            end
        end
    end

    // State registers; reset wins over clk_en, otherwise clk_en low freezes everything.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctrl_r <= RTOC_CONTROL_RESET;
            mode_r <= RTOC_PIN_MODE_RESET[WIDTH-1:0];
            buf_r <= '0;
            latch_r <= '0;
            ext_prev_r <= 1'b0;
        end
        else if (clk_en)
        begin
            ctrl_r <= ctrl_nxt;
            mode_r <= mode_nxt;
            buf_r <= buf_nxt;
            latch_r <= latch_nxt;
            ext_prev_r <= ext_prev_nxt;
        end
    end

    // Read mux; buffer bits in port mode read as zero.
    always_comb
    begin
        sfr_hit = 1'b1;
        sfr_rdata = 8'h00;
        unique case (sfr_addr)
            RTOC_ADDR_CONTROL: sfr_rdata = ctrl_r;
            RTOC_ADDR_PIN_MODE: sfr_rdata = mode_r;
            RTOC_ADDR_BUF_LOW,
            RTOC_ADDR_BUF_HIGH: sfr_rdata = buf_r & mode_r;
            default: sfr_hit = 1'b0;
        endcase
    end

    // Pins: marked bits mix both latches, others pass the port latch.
    assign rto_pin_sel = mode_r;
    assign rto_output_pins = (mode_r & (port_latch | latch_r))
        | (~mode_r & port_latch);

    chk_reset_ctrl: assert property (@(posedge clk)
        rst |=> ctrl_r == RTOC_CONTROL_RESET)
        else $error("control not cleared by reset");
    chk_enable_copy: assert property (@(posedge clk) disable iff (rst)
        clk_en && en_rise |=> latch_r == $past(buf_r))
        else $error("enable edge did not copy buffers");
    chk_no_xfer_off: assert property (@(posedge clk) disable iff (rst)
        clk_en && !ctl.enable && !en_rise |=> $stable(latch_r))
        else $error("latch moved while disabled");
    chk_lo_xfer: assert property (@(posedge clk) disable iff (rst)
        clk_en && ctl.enable && trig_lo && !en_rise
        |=> latch_r[HALF-1:0] == $past(buf_r[HALF-1:0]))
        else $error("low nibble transfer missed");
    chk_hi_xfer: assert property (@(posedge clk) disable iff (rst)
        clk_en && ctl.enable && trig_hi && !en_rise
        |=> latch_r[WIDTH-1:HALF] == $past(buf_r[WIDTH-1:HALF]))
        else $error("high nibble transfer missed");
    chk_byte_route: assert property (@(posedge clk) disable iff (rst)
        ctl.byte_mode && !ctl.ext_sel |-> trig_hi == timer_one_match_irq
        && trig_lo == timer_one_match_irq)
        else $error("byte mode routing wrong");
    chk_pin_mix: assert property (@(posedge clk) disable iff (rst)
        rto_output_pins == ((port_latch | (latch_r & mode_r))))
        else $error("pin mix wrong");
    chk_mode_write: assert property (@(posedge clk) disable iff (rst)
        clk_en && wr_mode |=> mode_r == $past(sfr_wdata[WIDTH-1:0]))
        else $error("pin mode write lost");
    chk_nibble_write: assert property (@(posedge clk) disable iff (rst)
        clk_en && wr_lo && !ctl.byte_mode
        |=> $stable(buf_r[WIDTH-1:HALF]))
        else $error("low write touched high nibble");
    chk_ext_select: assert property (@(posedge clk) disable iff (rst)
        !ctl.ext_sel |-> trig_lo == timer_one_match_irq
        && trig_hi == (ctl.byte_mode ? timer_one_match_irq
        : timer_two_match_irq))
        else $error("external trigger used while deselected");

    // Enable edge: a control write with bit 7 set while still disabled.
    sequence seq_enable_write;
        clk_en && wr_ctrl && sfr_wdata[RTOC_BIT_ENABLE] && !ctl.enable;
    endsequence
    // The enable bit and the buffer copy must land on the same edge.
    chk_enable_latch: assert property (@(posedge clk) disable iff (rst)
        seq_enable_write |=> ctl.enable && latch_r == $past(buf_r))
        else $error("enable write did not start output");
    // Port-mode pins never show real-time data.
    chk_port_bits: assert property (@(posedge clk) disable iff (rst)
        (rto_output_pins & ~mode_r) == (port_latch & ~mode_r))
        else $error("port mode pin shows real-time data");
    // Reads of the high buffer address mask port-mode bits to zero.
    chk_buf_read: assert property (@(posedge clk) disable iff (rst)
        sfr_addr == RTOC_ADDR_BUF_HIGH
        |-> (sfr_rdata & ~mode_r) == 8'h00)
        else $error("port mode buffer bit read as one");
endmodule
`default_nettype wire
